/* dv/tb_top.sv */
// Self-checking bench of the keyed watchdog
`timescale 1ns/1ns
`default_nettype none
`include "wdk_consts.svh"
module tb_top;
    logic        clk, srst, hsel, hwrite, xtal, rc, clr_ins, halt_ins, lp_mode, pin_n, rd_stb;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic        hreadyout, hresp, device_reset, pc_sp_clear, irq;
    logic [1:0]  ev_q[$];
    logic [31:0] rd_q[$];
    string       nm_q[$];
    int          n_errors, total_checks;
    logic [4:0]  k;
    wdk_top dut (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .external_slow_crystal(xtal),
        .internal_slow_rc(rc), .clear_watchdog_instruction(clr_ins),
        .halt_instruction(halt_ins), .low_power_mode(lp_mode), .external_reset_pin_n(pin_n),
        .device_reset(device_reset), .pc_sp_clear(pc_sp_clear), .irq(irq)
    );
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk_rd(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_rd
    task automatic chk_out(input string n, input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask : chk_out
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= 32'(a);
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        if (w) hwdata <= d;
        else begin
            rd_q.push_back(d);
            nm_q.push_back($sformatf("hrdata at %h", a));
            rd_stb <= 1'b1;
        end
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_stb <= 1'b0;
    endtask : bus
    task automatic ticks(input logic x, input int n);
        repeat (n) begin
            if (x) xtal <= 1'b1;
            else rc <= 1'b1;
            repeat (4) @(posedge clk);
            xtal <= 1'b0;
            rc <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : ticks
    task automatic pulse(input int c);
        clr_ins <= (c == 0);
        halt_ins <= (c == 1);
        pin_n <= (c != 2);
        repeat (2) @(posedge clk);
        clr_ins <= 1'b0;
        halt_ins <= 1'b0;
        pin_n <= 1'b1;
        @(posedge clk);
    endtask : pulse
    task automatic chkpt(input logic e);
        @(negedge clk);
        chk_out("irq", {1'b0, e}, {1'b0, irq});
        chk_out("pending reset requests", 2'b00, {1'b0, ev_q.size() != 0});
        @(posedge clk);
    endtask : chkpt
    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // ****************************************
    // Monitor, clock, watchdog, sequence
    // ****************************************
    always @(posedge clk) begin
        if (rd_stb === 1'b1 && hreadyout === 1'b1) chk_rd(nm_q.pop_front(), rd_q.pop_front(), hrdata);
        if (device_reset === 1'b1 || pc_sp_clear === 1'b1) begin
            if (ev_q.size() == 0) chk_out("unexpected request", 2'b00, {device_reset, pc_sp_clear});
            else chk_out("request kind", ev_q.pop_front(), {device_reset, pc_sp_clear});
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial begin
        {srst, hsel, hwrite, xtal, rc, clr_ins, halt_ins, lp_mode, pin_n, rd_stb} = 10'b10_0000_0010;
        {haddr, hwdata, htrans} = '0;
        k = 5'($urandom(32'h0000_f9a5));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(0, `WDK_OFS_CTRL, 32'h0000_0053);
        bus(0, `WDK_OFS_CAUSE, 0);
        bus(0, `WDK_OFS_STATUS, 0);
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 0);
        for (int p = 0; p < 2; p++) begin
            lp_mode <= p[0];
            bus(1, `WDK_OFS_IRQ_MASK, 32'(p));
            bus(1, `WDK_OFS_CTRL, 32'({`WDK_KEY_ENABLE, p[2:0]}));
            ticks(0, p ? 1023 : 255);
            chkpt(0);
            ev_q.push_back(p ? 2'b01 : 2'b10);
            ticks(0, 1);
            chkpt(p[0]);
            bus(0, `WDK_OFS_STATUS, 1);
            bus(1, `WDK_OFS_STATUS, 1);
            bus(1, `WDK_OFS_IRQ_MASK, 1);
            chkpt(1);
            bus(1, `WDK_OFS_IRQ_ST, 1);
            chkpt(0);
        end
        lp_mode <= 1'b0;
        bus(1, `WDK_OFS_CTRL, 32'({`WDK_KEY_ENABLE, 3'b000}));
        for (int c = 0; c < 3; c++) begin
            repeat (2) begin
                ticks(0, 200);
                pulse(c);
            end
            chkpt(0);
        end
        bus(1, `WDK_OFS_CLKCTL, 1);
        ticks(0, 300);
        chkpt(0);
        ev_q.push_back(2'b10);
        ticks(1, 256);
        chkpt(1);
        bus(1, `WDK_OFS_IRQ_ST, 3);
        bus(1, `WDK_OFS_CLKCTL, 0);
        bus(1, `WDK_OFS_CTRL, 32'({`WDK_KEY_DISABLE, 3'b000}));
        ticks(0, 300);
        chkpt(0);
        while (k == `WDK_KEY_ENABLE || k == `WDK_KEY_DISABLE) k = 5'($urandom());
        bus(1, `WDK_OFS_CTRL, 32'({k, 3'b000}));
        @(posedge clk);
        ticks(0, 2);
        chkpt(0);
        ev_q.push_back(2'b10);
        ticks(0, 1);
        chkpt(0);
        bus(0, `WDK_OFS_CAUSE, 1);
        bus(0, `WDK_OFS_CTRL, 32'h0000_0053);
        bus(0, `WDK_OFS_IRQ_ST, 2);
        ticks(0, 3);
        chkpt(0);
        bus(0, `WDK_OFS_CAUSE, 1);
        bus(1, `WDK_OFS_CAUSE, 0);
        bus(0, `WDK_OFS_CAUSE, 0);
        bus(1, `WDK_OFS_IRQ_MASK, 2);
        chkpt(1);
        bus(1, `WDK_OFS_IRQ_ST, 2);
        chkpt(0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

/* dv/wdk_assertions.sv */
// Concurrent checks on the keyed watchdog ports
`timescale 1ns/1ns
`default_nettype none
module wdk_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Events and outputs
    input wire logic        clear_watchdog_instruction,
    input wire logic        halt_instruction,
    input wire logic        low_power_mode,
    input wire logic        external_reset_pin_n,
    input wire logic        device_reset,
    input wire logic        pc_sp_clear,
    input wire logic        irq
);
    // ****************************************
    // Properties
    // ****************************************
    logic wr_d;
    always_ff @(posedge clk) wr_d <= !srst && hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence rd_s; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence clr_s; clear_watchdog_instruction || halt_instruction || !external_reset_pin_n; endsequence
    sequence pulse_s; device_reset || pc_sp_clear; endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    pulse_single_a: assert property (pulse_s |=> !device_reset && !pc_sp_clear)
        else $error("reset request longer than one cycle");
    reset_quiet_a: assert property ($past(srst) |-> !device_reset && !pc_sp_clear && !irq)
        else $error("outputs active after reset");
    rd_upper_a: assert property (rd_s |=> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    rd_unmapped_a: assert property (rd_s ##0 haddr[7:0] > 8'h14 |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    clear_block_a: assert property (clr_s |=> !pc_sp_clear)
        else $error("overflow despite counter clear");
    lp_clear_a: assert property (pc_sp_clear |-> $past(low_power_mode))
        else $error("partial clear outside low power");
    irq_cause_a: assert property ($rose(irq) |-> $past(wr_d) or ##[0:1] pulse_s)
        else $error("interrupt without cause");
endmodule : wdk_chk
bind wdk_top wdk_chk u_chk (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clear_watchdog_instruction(clear_watchdog_instruction),
    .halt_instruction(halt_instruction), .low_power_mode(low_power_mode),
    .external_reset_pin_n(external_reset_pin_n), .device_reset(device_reset),
    .pc_sp_clear(pc_sp_clear), .irq(irq)
);
`default_nettype wire

/* verilog/wdk_consts.svh */
// Constants of the keyed watchdog: offsets, fields, resets, counts
`ifndef WDK_CONSTS_SVH
`define WDK_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define WDK_OFS_CTRL     8'h00
`define WDK_OFS_CAUSE    8'h04
`define WDK_OFS_CLKCTL   8'h08
`define WDK_OFS_STATUS   8'h0C
`define WDK_OFS_IRQ_ST   8'h10
`define WDK_OFS_IRQ_MASK 8'h14
// ****************************************
// Fields
// ****************************************
`define WDK_KEY_MSB      7
`define WDK_KEY_LSB      3
`define WDK_PER_MSB      2
`define WDK_PER_LSB      0
`define WDK_KEY_ENABLE   5'h0A
`define WDK_KEY_DISABLE  5'h15
`define WDK_CAUSE_KEY    0
`define WDK_CLK_SRC      0
`define WDK_STAT_TO      0
`define WDK_IRQ_OVF      0
`define WDK_IRQ_KEY      1
// ****************************************
// Reset values and counts
// ****************************************
`define WDK_CTRL_RST     8'h53
`define WDK_KEY_FAULT_RC 2'h3
`define WDK_CNT_W        18
`endif

/* verilog/wdk_count.sv */
// Watchdog counter with selectable division ratio
`timescale 1ns/1ns
`default_nettype none
`include "wdk_consts.svh"
module wdk_count (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Control
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [2:0] period_sel,
    // Result
    output logic            overflow,
    output logic [`WDK_CNT_W-1:0] count
);
    // Last count before wrap for each period code
    function automatic logic [`WDK_CNT_W-1:0] last_count(
        input logic [2:0] sel
    );
        logic [4:0] shift;
        case (sel)
            3'd0:    shift = 5'd8;
            3'd1:    shift = 5'd10;
            3'd2:    shift = 5'd12;
            3'd3:    shift = 5'd14;
            3'd4:    shift = 5'd15;
            3'd5:    shift = 5'd16;
            3'd6:    shift = 5'd17;
            default: shift = 5'd18;
        endcase
        last_count = `WDK_CNT_W'((19'h0_0001 << shift) - 19'h0_0001);
    endfunction : last_count

    logic at_end;
    assign at_end   = count >= last_count(period_sel);
    assign overflow = run & tick & at_end & ~clear;

    always_ff @(posedge clk) begin
        if (srst || clear || !run) begin
            count <= '0;
        end else if (tick) begin
            count <= at_end ? '0 : count + 1'b1;
        end
    end
endmodule : wdk_count
`default_nettype wire

/* verilog/wdk_pkg.sv */
// Types of the keyed watchdog
`default_nettype none
package wdk_pkg;
    // Key fault sequencer, Gray coded except the FIRE to IDLE step
    typedef enum logic [1:0] {
        WDK_FLT_IDLE  = 2'b00,
        WDK_FLT_ARMED = 2'b01,
        WDK_FLT_FIRE  = 2'b11
    } wdk_flt_t;
endpackage : wdk_pkg
`default_nettype wire

/* verilog/wdk_tick.sv */
// Slow clock source select and edge ticks
`timescale 1ns/1ns
`default_nettype none
module wdk_tick (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Slow clocks
    input  wire logic external_slow_crystal,
    input  wire logic internal_slow_rc,
    input  wire logic slow_clock_source_select,
    // Ticks
    output logic      wdt_tick,
    output logic      rc_tick
);
    logic xtal_q;
    logic rc_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            xtal_q <= 1'b0;
            rc_q   <= 1'b0;
        end else begin
            xtal_q <= external_slow_crystal;
            rc_q   <= internal_slow_rc;
        end
    end

    assign rc_tick  = internal_slow_rc & ~rc_q;
    // Source 1 is the crystal, 0 the RC
    assign wdt_tick = slow_clock_source_select ?
                      (external_slow_crystal & ~xtal_q) : rc_tick;
endmodule : wdk_tick
`default_nettype wire

/* verilog/wdk_top.sv */
// Keyed watchdog timer with AHB-Lite registers
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wdk_consts.svh"
module wdk_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Slow clocks
    input  wire logic        external_slow_crystal,
    input  wire logic        internal_slow_rc,
    // Core events
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        halt_instruction,
    input  wire logic        low_power_mode,
    input  wire logic        external_reset_pin_n,
    // Reset requests and interrupt
    output logic             device_reset,
    output logic             pc_sp_clear,
    output logic             irq
);
    // ****************************************
    // Internal signals
    // ****************************************
    logic [7:0]             watchdog_control;
    logic                   key_fault_reset_flag;
    logic                   slow_clock_source_select;
    logic                   timeout_flag;
    logic [1:0]             irq_status;
    logic [1:0]             irq_mask;
    logic                   wdt_tick;
    logic                   rc_tick;
    logic                   overflow;
    logic [`WDK_CNT_W-1:0]  count;
    logic                   run;
    logic                   key_bad;
    logic                   key_fault;
    logic                   cnt_clear;
    logic [4:0]             key;
    logic [1:0]             rc_seen;
    wdk_pkg::wdk_flt_t      flt_state;
    wdk_pkg::wdk_flt_t      next_flt_state;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic                   wr_en;
    logic                   rd_req;
    logic                   wr_ctrl;
    logic                   wr_cause;
    logic                   wr_clkctl;
    logic                   wr_status;
    logic                   wr_irq_st;
    logic                   wr_irq_mask;
    logic                   ovf_full;
    logic                   ovf_part;

    // ****************************************
    // Bus slave
    // ****************************************
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_req    = hsel & hready & htrans[1] & ~hwrite;

    // Register decode shared by read and write
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `WDK_OFS_CTRL:     reg_index = 3'd1;
            `WDK_OFS_CAUSE:    reg_index = 3'd2;
            `WDK_OFS_CLKCTL:   reg_index = 3'd3;
            `WDK_OFS_STATUS:   reg_index = 3'd4;
            `WDK_OFS_IRQ_ST:   reg_index = 3'd5;
            `WDK_OFS_IRQ_MASK: reg_index = 3'd6;
            default:           reg_index = 3'd0;
        endcase
    endfunction : reg_index

    // Read word of one register, upper bits zero
    function automatic logic [31:0] read_word(input logic [2:0] idx);
        case (idx)
            3'd1:    read_word = {24'h00_0000, watchdog_control};
            3'd2:    read_word = {31'h0000_0000, key_fault_reset_flag};
            3'd3:    read_word = {31'h0000_0000, slow_clock_source_select};
            3'd4:    read_word = {31'h0000_0000, timeout_flag};
            3'd5:    read_word = {30'h0000_0000, irq_status};
            3'd6:    read_word = {30'h0000_0000, irq_mask};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // Address phase capture for writes
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend <= 1'b0;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_addr <= haddr[7:0];
        end
    end

    assign wr_en = wr_pend;

    // ****************************************
    // Write strobes
    // ****************************************
    // One strobe per register in the data phase
    always_comb begin
        wr_ctrl     = 1'b0;
        wr_cause    = 1'b0;
        wr_clkctl   = 1'b0;
        wr_status   = 1'b0;
        wr_irq_st   = 1'b0;
        wr_irq_mask = 1'b0;
        if (wr_en) begin
            case (reg_index(wr_addr))
                3'd1:    wr_ctrl     = 1'b1;
                3'd2:    wr_cause    = 1'b1;
                3'd3:    wr_clkctl   = 1'b1;
                3'd4:    wr_status   = 1'b1;
                3'd5:    wr_irq_st   = 1'b1;
                3'd6:    wr_irq_mask = 1'b1;
                default: wr_ctrl     = 1'b0;
            endcase
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata <= read_word(reg_index(haddr[7:0]));
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            watchdog_control <= `WDK_CTRL_RST;
        end else if (key_fault) begin
            watchdog_control <= `WDK_CTRL_RST;
        end else if (wr_ctrl) begin
            watchdog_control <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            slow_clock_source_select <= 1'b0;
        end else if (wr_clkctl) begin
            slow_clock_source_select <= hwdata[`WDK_CLK_SRC];
        end
    end

    assign key     = watchdog_control[`WDK_KEY_MSB:`WDK_KEY_LSB];
    assign run     = (key == `WDK_KEY_ENABLE);
    assign key_bad = (key != `WDK_KEY_ENABLE) && (key != `WDK_KEY_DISABLE);

    // ****************************************
    // Key fault sequencer
    // ****************************************
    always_comb begin
        next_flt_state = flt_state;
        case (flt_state)
            wdk_pkg::WDK_FLT_IDLE: begin
                if (key_bad) begin
                    next_flt_state = wdk_pkg::WDK_FLT_ARMED;
                end
            end
            wdk_pkg::WDK_FLT_ARMED: begin
                if (!key_bad) begin
                    next_flt_state = wdk_pkg::WDK_FLT_IDLE;
                end else if (rc_tick && rc_seen == `WDK_KEY_FAULT_RC - 2'h1) begin
                    next_flt_state = wdk_pkg::WDK_FLT_FIRE;
                end
            end
            wdk_pkg::WDK_FLT_FIRE: begin
                next_flt_state = wdk_pkg::WDK_FLT_IDLE;
            end
            default: begin
                next_flt_state = wdk_pkg::WDK_FLT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flt_state <= wdk_pkg::WDK_FLT_IDLE;
        end else begin
            flt_state <= next_flt_state;
        end
    end

    // RC edges seen since the key went bad
    always_ff @(posedge clk) begin
        if (srst || flt_state != wdk_pkg::WDK_FLT_ARMED) begin
            rc_seen <= 2'h0;
        end else if (rc_tick) begin
            rc_seen <= rc_seen + 2'h1;
        end
    end

    assign key_fault = (flt_state == wdk_pkg::WDK_FLT_FIRE);

    // ****************************************
    // Counter
    // ****************************************
    assign cnt_clear = clear_watchdog_instruction
                     | halt_instruction
                     | ~external_reset_pin_n
                     | key_fault;

    wdk_tick u_tick (
        .clk                      (clk),
        .srst                     (srst),
        .external_slow_crystal    (external_slow_crystal),
        .internal_slow_rc         (internal_slow_rc),
        .slow_clock_source_select (slow_clock_source_select),
        .wdt_tick                 (wdt_tick),
        .rc_tick                  (rc_tick)
    );

    wdk_count u_count (
        .clk        (clk),
        .srst       (srst),
        .tick       (wdt_tick),
        .run        (run),
        .clear      (cnt_clear),
        .period_sel (watchdog_control[`WDK_PER_MSB:`WDK_PER_LSB]),
        .overflow   (overflow),
        .count      (count)
    );

    // ****************************************
    // Reset requests
    // ****************************************
    // Overflow outcome depends on the power mode
    assign ovf_full = overflow & ~low_power_mode;
    assign ovf_part = overflow & low_power_mode;

    always_ff @(posedge clk) begin
        if (srst) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= key_fault | ovf_full;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_sp_clear <= 1'b0;
        end else begin
            pc_sp_clear <= ovf_part;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            key_fault_reset_flag <= 1'b0;
        end else if (key_fault) begin
            key_fault_reset_flag <= 1'b1;
        end else if (wr_cause) begin
            key_fault_reset_flag <= hwdata[`WDK_CAUSE_KEY];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timeout_flag <= 1'b0;
        end else if (overflow) begin
            timeout_flag <= 1'b1;
        end else if (halt_instruction) begin
            timeout_flag <= 1'b0;
        end else if (wr_status && hwdata[`WDK_STAT_TO]) begin
            timeout_flag <= 1'b0;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `WDK_IRQ_OVF && overflow) || (i == `WDK_IRQ_KEY && key_fault)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_irq_st && hwdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask <= 2'h0;
        end else if (wr_irq_mask) begin
            irq_mask <= hwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule : wdk_top
`default_nettype wire
